// ==== rtl/ivb_top.sv ====
// Notes on behaviour
// - Flash word zero is the user entry
// - Power-fail warning dispatches to vector 08
// - Enabled external pins share vector 10
// - Metrology accumulation done dispatches to 18
// - Any I2C event dispatches to 20
// - SPI character shifted dispatches to 28
// - Any UART event dispatches to 30
// - Smart card zero exception dispatches 38
// - Watchdog warning dispatches to 48
// - Any timer channel event dispatches 50
// - Corrupted fuse trim dispatches to 58
// - Any RTC source dispatches to 60
// - Enabled touch activation dispatches to 70
// - Enabled crypto completion dispatches to 78
// - Enabled remote sampler event dispatches 80
// - Other conditions go to catch-all 88
// - Reset starts fetching at boot ROM base
// - JTAG loader flag diverts boot to loader
// - Load stack pointer from byte address zero
// - Then load program counter from address four
// - Code map: flash at zero, ROM high
// - Data map: four RAM regions at bases
`timescale 1ns/1ps
module ivb_top
    import ivb_pkg::*;
#(
    parameter int FLASH_WORDS = FLASH_WORDS_LARGE,
    parameter int INIT_CYCLES = BOOT_INIT_CYC
)(
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire ivb_evt_t          EVT,
    input  wire ivb_en_t           EN,
    input  wire logic              IRQ_ACK,
    input  wire logic              JTAG_LOADER_SET,
    input  wire logic              JTAG_LOADER_CLR,
    input  wire logic [31:0]       FLASH_RD_DATA,
    input  wire logic              FLASH_RD_VALID,
    input  wire logic [ADDR_W-1:0] CODE_ADDR,
    input  wire logic [ADDR_W-1:0] DATA_ADDR,
    output logic                   IRQ_REQ,
    output logic [ADDR_W-1:0]      IRQ_VECTOR,
    output logic [IDX_W-1:0]       IRQ_SRC,
    output logic [NUM_SRC-1:0]     IRQ_PENDING,
    output logic                   FLASH_RD_REQ,
    output logic [ADDR_W-1:0]      FLASH_RD_ADDR,
    output logic [31:0]            STACK_PTR,
    output logic [31:0]            PROG_CNTR,
    output logic                   BOOT_DONE,
    output logic                   LOADER_ACTIVE,
    output logic                   LOADER_FLAG,
    output ivb_code_sel_t          CODE_SEL,
    output ivb_data_sel_t          DATA_SEL
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (INIT_CYCLES < 1 || INIT_CYCLES > 255)
        $error("ivb_top: INIT_CYCLES must be 1 to 255");

    // Last count of the wait
    localparam logic [7:0] INIT_LAST = 8'(INIT_CYCLES - 1);

    // ************************************************************
    // State of the block
    // ************************************************************
    typedef struct packed {
        ivb_boot_st_t        boot_st;     // Boot sequencer state
        logic [7:0]          init_cnt;    // Initialisation wait
        logic                loader_flag; // Loader requested
        logic [NUM_SRC-1:0]  pend;        // Sticky pending flags
        logic [NUM_SRC-1:0]  raw_prev;    // Source level last cycle
        logic                irq_req;     // Dispatch offered
        logic [ADDR_W-1:0]   irq_vec;     // Offered vector
        logic [IDX_W-1:0]    irq_idx;     // Offered source
        logic                rd_req;      // Flash read request
        logic [ADDR_W-1:0]   rd_addr;     // Flash read address
        logic [31:0]         sp;          // Stack pointer
        logic [31:0]         pc;          // Program counter
        logic                boot_done;   // User code running
        logic                loader_act;  // Loader running
        ivb_code_sel_t       code_sel;    // Registered code decode
        ivb_data_sel_t       data_sel;    // Registered data decode
    } ivb_state_t;

    ivb_state_t st_reg;                   // Current state
    ivb_state_t st_next;                  // Next state

    // Combinational helpers
    logic [NUM_SRC-1:0] raw;              // Conditioned source levels
    logic [NUM_SRC-1:0] rise;             // New activations
    logic [NUM_SRC-1:0] eligible;         // Pending and enabled
    logic               pick_any;         // Something to dispatch
    logic [IDX_W-1:0]   pick_idx;         // Winning source
    ivb_code_sel_t      code_sel_c;       // Decoder outputs
    ivb_data_sel_t      data_sel_c;

    // ************************************************************
    // Source conditioning
    // ************************************************************

    // Fold each peripheral group into its one request
    always_comb
    begin
        raw              = '0;
        raw[SRC_PWR]     = EVT.pwr_fail;
        raw[SRC_EXT]     = |(EVT.ext_act & EN.ext_pin_en);
        raw[SRC_CE]      = EVT.ce_done;
        raw[SRC_I2C]     = |EVT.i2c_evt;
        raw[SRC_SPI]     = EVT.spi_done;
        raw[SRC_UART]    = |EVT.uart_evt;
        raw[SRC_SMART_CARD_CHANNEL_ZERO]    = EVT.smart_card_channel_zero_exc;
        raw[SRC_WDT]     = EVT.wdt_warn;
        raw[SRC_TMR]     = |EVT.tmr_evt;
        raw[SRC_FUSE]    = EVT.fuse_bad;
        raw[SRC_RTC]     = |EVT.rtc_evt;
        raw[SRC_TOUCH]   = EVT.touch_act & EN.touch_en;
        raw[SRC_CRYPTO]  = EVT.crypto_done & EN.crypto_en;
        raw[SRC_REMOTE]  = |EVT.remote_evt & EN.remote_en;
        raw[SRC_TRAP]    = EVT.other_irq;
    end

    // Activation is the rising edge of each level
    assign rise     = raw & ~st_reg.raw_prev;
    assign eligible = st_reg.pend & EN.src_en;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Fixed priority, lowest index wins
    ivb_prio_pick #(
        .N   (NUM_SRC)
    ) u_pick (
        .req (eligible),
        .any (pick_any),
        .idx (pick_idx)
    );

    // Address decode, registered below
    ivb_addr_map #(
        .FLASH_WORDS (FLASH_WORDS)
    ) u_map (
        .code_addr   (CODE_ADDR),
        .data_addr   (DATA_ADDR),
        .code_sel    (code_sel_c),
        .data_sel    (data_sel_c)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        st_next          = st_reg;
        st_next.raw_prev = raw;
        st_next.code_sel = code_sel_c;
        st_next.data_sel = data_sel_c;

        // Loader flag, a set beats a clear
        if (JTAG_LOADER_SET)
        begin
            st_next.loader_flag = 1'b1;
        end
        else if (JTAG_LOADER_CLR)
        begin
            st_next.loader_flag = 1'b0;
        end

        // Acknowledge retires the offered source
        if (st_reg.irq_req && IRQ_ACK)
        begin
            st_next.pend[st_reg.irq_idx] = 1'b0;
            st_next.irq_req              = 1'b0;
        end
        // Offer the best candidate once user code runs
        else if (!st_reg.irq_req && st_reg.boot_done && pick_any)
        begin
            st_next.irq_req = 1'b1;
            st_next.irq_idx = pick_idx;
            st_next.irq_vec = VEC_TABLE[pick_idx];
        end

        // New activations latch, winning over a clear
        st_next.pend = st_next.pend | rise;

        // Boot sequencer
        st_next.rd_req = 1'b0;
        case (st_reg.boot_st)
            // Device initialisation inside boot ROM
            BT_INIT:
            begin
                if (st_reg.init_cnt == INIT_LAST)
                begin
                    st_next.boot_st = BT_CHECK;
                end
                else
                begin
                    st_next.init_cnt = st_reg.init_cnt + 8'h01;
                end
            end

            // Loader or user code
            BT_CHECK:
            begin
                if (st_reg.loader_flag)
                begin
                    st_next.boot_st    = BT_LOADER;
                    st_next.loader_act = 1'b1;
                end
                else
                begin
                    st_next.boot_st = BT_RD_SP;
                end
            end

            // Fetch the stack word
            BT_RD_SP:
            begin
                st_next.rd_req  = 1'b1;
                st_next.rd_addr = SP_BYTE_ADDR;
                st_next.boot_st = BT_WAIT_SP;
            end
            BT_WAIT_SP:
            begin
                if (FLASH_RD_VALID)
                begin
                    st_next.sp      = FLASH_RD_DATA;
                    st_next.boot_st = BT_RD_PC;
                end
            end

            // Fetch the entry word
            BT_RD_PC:
            begin
                st_next.rd_req  = 1'b1;
                st_next.rd_addr = PC_BYTE_ADDR;
                st_next.boot_st = BT_WAIT_PC;
            end
            BT_WAIT_PC:
            begin
                if (FLASH_RD_VALID)
                begin
                    st_next.pc        = FLASH_RD_DATA;
                    st_next.boot_done = 1'b1;
                    st_next.boot_st   = BT_RUN;
                end
            end

            // Terminal states until the next reset
            BT_RUN:    st_next.boot_st = BT_RUN;
            BT_LOADER: st_next.boot_st = BT_LOADER;
            default:   st_next.boot_st = BT_INIT;
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            // Parked in the boot ROM
            st_reg         <= '0;
            st_reg.boot_st <= BT_INIT;
            st_reg.sp      <= SP_RESET;
            st_reg.pc      <= {8'h00, BOOT_ROM_BASE};
            st_reg.rd_addr <= VEC_USER_ENTRY;
            st_reg.irq_vec <= VEC_USER_ENTRY;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // Outputs, all from the state register
    // ************************************************************
    // Dispatch port
    assign IRQ_REQ       = st_reg.irq_req;
    assign IRQ_VECTOR    = st_reg.irq_vec;
    assign IRQ_SRC       = st_reg.irq_idx;
    assign IRQ_PENDING   = st_reg.pend;
    // Boot read port
    assign FLASH_RD_REQ  = st_reg.rd_req;
    assign FLASH_RD_ADDR = st_reg.rd_addr;
    // Boot results
    assign STACK_PTR     = st_reg.sp;
    assign PROG_CNTR     = st_reg.pc;
    assign BOOT_DONE     = st_reg.boot_done;
    assign LOADER_ACTIVE = st_reg.loader_act;
    assign LOADER_FLAG   = st_reg.loader_flag;
    // Address decode
    assign CODE_SEL      = st_reg.code_sel;
    assign DATA_SEL      = st_reg.data_sel;

endmodule // ivb_top

// ==== rtl/ivb_pkg.sv ====
package ivb_pkg;

    // ************************************************************
    // Sizes of the request groups
    // ************************************************************
    localparam int NUM_SRC   = 15;   // Dispatchable sources
    localparam int IDX_W     = 4;    // Width of a source index
    localparam int EXT_PINS  = 8;    // External interrupt pins
    localparam int UARTS     = 4;    // UART channels
    localparam int TIMERS    = 5;    // Timer channels
    localparam int RTC_SRCS  = 3;    // Alarm, supply, temperature
    localparam int ADDR_W    = 24;   // Code and data address width

    // ************************************************************
    // Source indices, lowest index has the highest priority
    // ************************************************************
    localparam int SRC_PWR    = 0;
    localparam int SRC_EXT    = 1;
    localparam int SRC_CE     = 2;
    localparam int SRC_I2C    = 3;
    localparam int SRC_SPI    = 4;
    localparam int SRC_UART   = 5;
    localparam int SRC_SMART_CARD_CHANNEL_ZERO   = 6;
    localparam int SRC_WDT    = 7;
    localparam int SRC_TMR    = 8;
    localparam int SRC_FUSE   = 9;
    localparam int SRC_RTC    = 10;
    localparam int SRC_TOUCH  = 11;
    localparam int SRC_CRYPTO = 12;
    localparam int SRC_REMOTE = 13;
    localparam int SRC_TRAP   = 14;

    // ************************************************************
    // Code-space vectors
    // ************************************************************
    localparam logic [ADDR_W-1:0] VEC_USER_ENTRY = 24'h000000;
    localparam logic [ADDR_W-1:0] VEC_PWR        = 24'h000008;
    localparam logic [ADDR_W-1:0] VEC_EXT        = 24'h000010;
    localparam logic [ADDR_W-1:0] VEC_CE         = 24'h000018;
    localparam logic [ADDR_W-1:0] VEC_I2C        = 24'h000020;
    localparam logic [ADDR_W-1:0] VEC_SPI        = 24'h000028;
    localparam logic [ADDR_W-1:0] VEC_UART       = 24'h000030;
    localparam logic [ADDR_W-1:0] VEC_SMART_CARD_CHANNEL_ZERO       = 24'h000038;
    localparam logic [ADDR_W-1:0] VEC_WDT        = 24'h000048;
    localparam logic [ADDR_W-1:0] VEC_TMR        = 24'h000050;
    localparam logic [ADDR_W-1:0] VEC_FUSE       = 24'h000058;
    localparam logic [ADDR_W-1:0] VEC_RTC        = 24'h000060;
    localparam logic [ADDR_W-1:0] VEC_TOUCH      = 24'h000070;
    localparam logic [ADDR_W-1:0] VEC_CRYPTO     = 24'h000078;
    localparam logic [ADDR_W-1:0] VEC_REMOTE     = 24'h000080;
    localparam logic [ADDR_W-1:0] VEC_TRAP       = 24'h000088;

    // Vector per source index, element 0 is power-fail
    localparam logic [NUM_SRC-1:0][ADDR_W-1:0] VEC_TABLE = {
        VEC_TRAP, VEC_REMOTE, VEC_CRYPTO, VEC_TOUCH, VEC_RTC,
        VEC_FUSE, VEC_TMR, VEC_WDT, VEC_SMART_CARD_CHANNEL_ZERO, VEC_UART,
        VEC_SPI, VEC_I2C, VEC_CE, VEC_EXT, VEC_PWR};

    // ************************************************************
    // Boot addresses and timing
    // ************************************************************
    localparam logic [ADDR_W-1:0] BOOT_ROM_BASE = 24'h800000;
    localparam logic [ADDR_W-1:0] SP_BYTE_ADDR  = 24'h000000;
    localparam logic [ADDR_W-1:0] PC_BYTE_ADDR  = 24'h000004;
    localparam logic [31:0]       SP_RESET      = 32'h00000000;
    localparam int                BOOT_INIT_CYC = 16;

    // ************************************************************
    // Memory map, word addresses and sizes
    // ************************************************************
    localparam int FLASH_WORDS_LARGE = 131072;
    localparam int FLASH_WORDS_SMALL = 65536;
    localparam logic [ADDR_W-1:0] FLASH_BASE = 24'h000000;
    localparam logic [ADDR_W-1:0] ROM_WORDS  = 24'h001000;
    localparam logic [ADDR_W-1:0] DRAM_BASE  = 24'h000000;
    localparam logic [ADDR_W-1:0] DRAM_WORDS = 24'h001800;
    localparam logic [ADDR_W-1:0] NVR_BASE   = 24'h001800;
    localparam logic [ADDR_W-1:0] NVR_WORDS  = 24'h000200;
    localparam logic [ADDR_W-1:0] DBG_BASE   = 24'h003e00;
    localparam logic [ADDR_W-1:0] DBG_WORDS  = 24'h000030;
    localparam logic [ADDR_W-1:0] CER_BASE   = 24'h004000;
    localparam logic [ADDR_W-1:0] CER_WORDS  = 24'h001000;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic                         pwr_fail;
        logic [EXT_PINS-1:0]          ext_act;
        logic                         ce_done;
        logic [4:0]                   i2c_evt;
        logic                         spi_done;
        logic [UARTS-1:0][3:0]        uart_evt;
        logic                         smart_card_channel_zero_exc;
        logic                         wdt_warn;
        logic [TIMERS-1:0][1:0]       tmr_evt;
        logic                         fuse_bad;
        logic [RTC_SRCS-1:0]          rtc_evt;
        logic                         touch_act;
        logic                         crypto_done;
        logic [1:0]                   remote_evt;
        logic                         other_irq;
    } ivb_evt_t;

    typedef struct packed {
        logic [EXT_PINS-1:0] ext_pin_en;
        logic                touch_en;
        logic                crypto_en;
        logic                remote_en;
        logic [NUM_SRC-1:0]  src_en;
    } ivb_en_t;

    typedef struct packed {
        logic flash;
        logic boot_rom;
        logic unmapped;
    } ivb_code_sel_t;

    typedef struct packed {
        logic cpu_ram;
        logic nv_ram;
        logic dbg_ram;
        logic ce_ram;
        logic unmapped;
    } ivb_data_sel_t;

    typedef enum logic [2:0] {
        BT_INIT, BT_CHECK, BT_RD_SP, BT_WAIT_SP,
        BT_RD_PC, BT_WAIT_PC, BT_RUN, BT_LOADER
    } ivb_boot_st_t;

endpackage

// ==== rtl/ivb_prio_pick.sv ====
`timescale 1ns/1ps
module ivb_prio_pick
    import ivb_pkg::*;
#(
    parameter int N = NUM_SRC
)(
    input  wire logic [N-1:0]     req,
    output logic                  any,
    output logic [IDX_W-1:0]      idx
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (N < 1 || N > (1 << IDX_W))
        $error("ivb_prio_pick: N does not fit the index width");

    // ************************************************************
    // Lowest set index wins
    // ************************************************************
    logic [N:0] seen;              // Any lower request present

    assign seen[0] = 1'b0;

    // Prefix of requests below each entry
    for (genvar g = 0; g < N; g++)
    begin : g_prefix
        assign seen[g+1] = seen[g] | req[g];
    end

    // Pick the first request from the bottom
    always_comb
    begin
        idx = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i] && !seen[i])
            begin
                idx = IDX_W'(i);
            end
        end
        any = seen[N];
    end

endmodule // ivb_prio_pick

// ==== rtl/ivb_addr_map.sv ====
`timescale 1ns/1ps
module ivb_addr_map
    import ivb_pkg::*;
#(
    parameter int FLASH_WORDS = FLASH_WORDS_LARGE
)(
    input  wire logic [ADDR_W-1:0] code_addr,
    input  wire logic [ADDR_W-1:0] data_addr,
    output ivb_code_sel_t          code_sel,
    output ivb_data_sel_t          data_sel
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (FLASH_WORDS != FLASH_WORDS_LARGE &&
        FLASH_WORDS != FLASH_WORDS_SMALL)
        $error("ivb_addr_map: unsupported flash size");

    localparam logic [ADDR_W-1:0] FLASH_TOP = ADDR_W'(FLASH_WORDS);

    // ************************************************************
    // Window test helper
    // ************************************************************
    function automatic logic in_win(logic [ADDR_W-1:0] a,
                                    logic [ADDR_W-1:0] base,
                                    logic [ADDR_W-1:0] size);
        in_win = (a >= base) && ((a - base) < size);
    endfunction

    // Code space decode
    always_comb
    begin
        code_sel          = '0;
        code_sel.flash    = in_win(code_addr, FLASH_BASE, FLASH_TOP);
        code_sel.boot_rom = in_win(code_addr, BOOT_ROM_BASE,
                                   ROM_WORDS);
        code_sel.unmapped = !code_sel.flash && !code_sel.boot_rom;
    end

    // Data space decode
    always_comb
    begin
        data_sel          = '0;
        data_sel.cpu_ram  = in_win(data_addr, DRAM_BASE, DRAM_WORDS);
        data_sel.nv_ram   = in_win(data_addr, NVR_BASE, NVR_WORDS);
        data_sel.dbg_ram  = in_win(data_addr, DBG_BASE, DBG_WORDS);
        data_sel.ce_ram   = in_win(data_addr, CER_BASE, CER_WORDS);
        data_sel.unmapped = !(data_sel.cpu_ram || data_sel.nv_ram ||
                              data_sel.dbg_ram || data_sel.ce_ram);
    end

endmodule // ivb_addr_map

// ==== tb/ivb_top_chk.sv ====
`timescale 1ns/1ps
// Watches the dispatch and boot outputs of the top module
module ivb_top_chk
    import ivb_pkg::*;
(
    input wire logic               CLK,
    input wire logic               RST,
    input wire ivb_en_t            EN,
    input wire logic               IRQ_ACK,
    input wire logic [31:0]        FLASH_RD_DATA,
    input wire logic               FLASH_RD_VALID,
    input wire logic               IRQ_REQ,
    input wire logic [ADDR_W-1:0]  IRQ_VECTOR,
    input wire logic [IDX_W-1:0]   IRQ_SRC,
    input wire logic [NUM_SRC-1:0] IRQ_PENDING,
    input wire logic               FLASH_RD_REQ,
    input wire logic [31:0]        PROG_CNTR,
    input wire logic               BOOT_DONE,
    input wire logic               LOADER_ACTIVE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Core takes the offer
    sequence taken_s; IRQ_REQ && IRQ_ACK; endsequence
    rd_pulse_a: assert property (FLASH_RD_REQ |=> !FLASH_RD_REQ)
        else $error("flash read request longer than one cycle");
    vec_map_a: assert property (IRQ_REQ |->
        IRQ_VECTOR == VEC_TABLE[IRQ_SRC])
        else $error("vector does not match offered source");
    no_early_a: assert property (IRQ_REQ |-> BOOT_DONE)
        else $error("offer before boot finished");
    offer_hold_a: assert property (IRQ_REQ && !IRQ_ACK |=>
        IRQ_REQ && $stable(IRQ_SRC))
        else $error("offer dropped or changed before ack");
    ack_drop_a: assert property (taken_s |=> !IRQ_REQ)
        else $error("offer still up after ack");
    prio_pick_a: assert property ($rose(IRQ_REQ) |->
        IRQ_PENDING[IRQ_SRC] && ($past(IRQ_PENDING) & $past(EN.src_en) &
        ((15'h1 << IRQ_SRC) - 15'h1)) == 15'h0)
        else $error("lower priority source offered first");
    loader_a: assert property (LOADER_ACTIVE |->
        !FLASH_RD_REQ && !BOOT_DONE)
        else $error("flash boot while loader runs");
    pc_rom_a: assert property (!BOOT_DONE |->
        PROG_CNTR == {8'h00, BOOT_ROM_BASE})
        else $error("fetch not at boot rom base");
    pc_load_a: assert property ($rose(BOOT_DONE) |->
        $past(FLASH_RD_VALID) && PROG_CNTR == $past(FLASH_RD_DATA))
        else $error("program counter not loaded from flash word");
endmodule // ivb_top_chk
bind ivb_top ivb_top_chk u_chk (.CLK(CLK), .RST(RST), .EN(EN),
    .IRQ_ACK(IRQ_ACK), .FLASH_RD_DATA(FLASH_RD_DATA),
    .FLASH_RD_VALID(FLASH_RD_VALID),
    .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_SRC(IRQ_SRC),
    .IRQ_PENDING(IRQ_PENDING), .FLASH_RD_REQ(FLASH_RD_REQ),
    .PROG_CNTR(PROG_CNTR), .BOOT_DONE(BOOT_DONE),
    .LOADER_ACTIVE(LOADER_ACTIVE));

// ==== tb/ivb_flash_mdl.sv ====
`timescale 1ns/1ps
// Flash answering boot reads after a chosen latency
module ivb_flash_mdl
    import ivb_pkg::*;
#(
    parameter logic [31:0] SP_WORD = 32'h00001800,
    parameter logic [31:0] PC_WORD = 32'h00000100
)(
    input  wire logic              clk,
    input  wire logic              req,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        lat,
    output logic [31:0]            data,
    output logic                   valid
);
    logic [7:0]        cnt  = 8'h00;   // Cycles until answer
    logic [ADDR_W-1:0] a    = '0;      // Address of open read
    logic [31:0]       last = 32'h0;   // Last word answered
    always_ff @(posedge clk)
    begin
        if (req)
            {cnt, a} <= {lat, addr};
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
        if (valid)
            last <= data;
    end
    assign valid = (cnt == 8'h01);
    // Outside the answer the bus shows the inverse, never a stale match
    assign data = !valid ? ~last : (a == PC_BYTE_ADDR ? PC_WORD : SP_WORD);
endmodule // ivb_flash_mdl

// ==== tb/interrupt_vector_and_boot_tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, a) chk(n, (e), (a))
module interrupt_vector_and_boot_tb;
    import ivb_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ack = 1'b0, jset = 1'b0, jclr = 1'b0;
    logic [52:0] ev = '0;
    ivb_en_t en = '1;
    logic [ADDR_W-1:0] caddr = '0, daddr = '0, vec, raddr;
    logic [7:0] lat = 8'h01;
    logic [31:0] fdata, sp, pc;
    logic [IDX_W-1:0] src;
    logic [NUM_SRC-1:0] pend;
    logic fvalid, irq, rreq, done, ldr, lflag;
    ivb_code_sel_t csel;
    ivb_data_sel_t dsel;
    int fails = 0, checks = 0;
    // Lowest bit of each source field, and its expected vector
    localparam int BP [15] = '{52,44,43,38,37,21,20,19,9,8,5,4,3,1,0};
    localparam logic [7:0] VX [15] = '{8'h08,8'h10,8'h18,8'h20,8'h28,
        8'h30,8'h38,8'h48,8'h50,8'h58,8'h60,8'h70,8'h78,8'h80,8'h88};
    always #12.5 clk = ~clk;
    ivb_top uut (.CLK(clk), .RST(rst), .EVT(ivb_evt_t'(ev)), .EN(en),
        .IRQ_ACK(ack), .JTAG_LOADER_SET(jset), .JTAG_LOADER_CLR(jclr),
        .FLASH_RD_DATA(fdata), .FLASH_RD_VALID(fvalid), .CODE_ADDR(caddr),
        .DATA_ADDR(daddr), .IRQ_REQ(irq), .IRQ_VECTOR(vec), .IRQ_SRC(src),
        .IRQ_PENDING(pend), .FLASH_RD_REQ(rreq), .FLASH_RD_ADDR(raddr),
        .STACK_PTR(sp), .PROG_CNTR(pc), .BOOT_DONE(done),
        .LOADER_ACTIVE(ldr), .LOADER_FLAG(lflag), .CODE_SEL(csel),
        .DATA_SEL(dsel));
    ivb_flash_mdl u_flash (.clk(clk), .req(rreq), .addr(raddr), .lat(lat),
        .data(fdata), .valid(fvalid));
    task automatic chk(string n, logic [31:0] e, logic [31:0] a);
        checks++;
        if (a !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", n, e, a);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic step(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bounded wait: 0 boot done, 1 offer, 2 loader
    task automatic wait_on(int w);
        for (int i = 0; i < 300; i++)
        begin
            if ((w == 0 && done === 1'b1) || (w == 1 && irq === 1'b1) ||
                (w == 2 && ldr === 1'b1))
                return;
            step();
        end
        fails++;
        give_verdict();
    endtask
    task automatic do_reset(bit load);
        rst = 1'b1;
        step(16);
        rst = 1'b0;
        jset = 1'b1;
        step();
        jset = 1'b0;
        jclr = !load;
        step();
        jclr = 1'b0;
    endtask
    // Takes the offer, expects source i and its vector
    task automatic serve(int i);
        wait_on(1);
        `CHK("source", i, src);
        `CHK("vector", {16'h0, VX[i]}, vec);
        step(2);
        ack = 1'b1;
        step();
        ack = 1'b0;
        `CHK("offer after ack", 1'b0, irq);
    endtask
    task automatic t_loader();
        do_reset(1'b1);
        wait_on(2);
        step(30);
        `CHK("loader", 2'b11, {ldr, lflag});
        `CHK("boot done", 1'b0, done);
        $display("test loader ended");
    endtask
    task automatic t_boot();
        lat = 8'h06;
        do_reset(1'b0);
        `CHK("reset pc", 32'h00800000, pc);
        wait_on(0);
        `CHK("stack", 32'h00001800, sp);
        `CHK("pc", 32'h00000100, pc);
        $display("test boot ended");
    endtask
    task automatic t_vectors();
        for (int i = 0; i < 15; i++)
        begin
            ev[BP[i]] = 1'b1;
            step();
            ev = '0;
            serve(i);
        end
        $display("test vectors ended");
    endtask
    task automatic t_prio();
        en.src_en[SRC_SPI] = 1'b0;
        en.touch_en = 1'b0;
        en.ext_pin_en[0] = 1'b0;
        ev = (53'h1 << BP[0]) | (53'h1 << BP[1]) | (53'h1 << BP[4]) |
            (53'h1 << BP[11]) | 53'h1;
        step();
        ev = '0;
        serve(0);
        serve(14);
        step(4);
        `CHK("masked", 2'b01, {irq, pend[SRC_SPI]});
        `CHK("touch off", 1'b0, pend[SRC_TOUCH]);
        `CHK("pin off", 1'b0, pend[SRC_EXT]);
        en = '1;
        serve(4);
        $display("test priority ended");
    endtask
    task automatic dec(logic [23:0] c, logic [23:0] d, logic [2:0] cs,
        logic [4:0] ds);
        {caddr, daddr} = {c, d};
        step();
        `CHK("code sel", cs, csel);
        `CHK("data sel", ds, dsel);
    endtask
    task automatic t_decode();
        dec(24'h800000, 24'h001800, 3'h2, 5'h08);
        dec(24'h01ffff, 24'h003e00, 3'h4, 5'h04);
        dec(24'h020000, 24'h004000, 3'h1, 5'h02);
        dec(24'h000000, 24'h000000, 3'h4, 5'h10);
        $display("test decode ended");
    endtask
    initial
    begin
        t_loader();
        t_boot();
        t_vectors();
        t_prio();
        t_decode();
        give_verdict();
    end
endmodule // interrupt_vector_and_boot_tb
